// ===== logic/sld_pkg.sv
// constants shared by the squib loop diagnostic control logic
// assumes a 250 MHz aclk and a 32-bit AXI4-Lite register port
package sld_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned AXI_AW = 5;

    // register byte offsets
    localparam logic [4:0] OFS_SYSTEM_CONFIG = 5'h00;
    localparam logic [4:0] OFS_LOOP_REQ = 5'h04;
    localparam logic [4:0] OFS_SYS_REQ = 5'h08;
    localparam logic [4:0] OFS_DIAG_CTL = 5'h0c;
    localparam logic [4:0] OFS_CONV_RES = 5'h10;
    localparam logic [4:0] OFS_LOOP_STAT = 5'h14;
    localparam logic [4:0] OFS_GND_LOSS = 5'h18;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // system_config fields
    localparam int unsigned CFG_AUTO_OFF = 0;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;

    // loop_diag_request fields
    localparam int unsigned LRQ_CH_LSB = 0;
    localparam int unsigned LRQ_PIN = 2;
    localparam int unsigned LRQ_SRC = 3;
    localparam int unsigned LRQ_SNK = 4;
    localparam int unsigned LRQ_MON = 5;
    localparam int unsigned LRQ_PD_OFF = 6;
    localparam int unsigned LRQ_MODE_LSB = 8;
    localparam logic [9:0] LRQ_RST = 10'h000;

    typedef enum logic [1:0] {
        MODE_LEAK = 2'h0,
        MODE_RES_STEP1 = 2'h1,
        MODE_RES_BYPASS = 2'h2,
        MODE_HIGH_RES = 2'h3
    } sld_mode_e;

    // diag_state_test_code values in system_diag_request bits [1:0]
    localparam logic [1:0] DST_NONE = 2'h0;
    localparam logic [1:0] DST_HS_FET = 2'h1;
    localparam logic [1:0] DST_LS_FET = 2'h2;
    localparam logic [1:0] DST_SAFING = 2'h3;

    // loop_diag_status fields
    localparam int unsigned ST_STB = 0;
    localparam int unsigned ST_STG = 1;
    localparam int unsigned ST_HR_UP = 2;
    localparam int unsigned ST_HR_LO = 3;
    localparam int unsigned ST_FET_ON = 4;
    localparam int unsigned ST_CH_LSB = 8;
    localparam int unsigned ST_PIN = 10;
    // conversion_result fields: data [9:0], valid flag
    localparam int unsigned RES_VALID = 15;

    // timing: fet_test_timeout is a longest time, ground filter a least time
    localparam int unsigned FET_TIMEOUT_NS = 2000;
    localparam int unsigned FET_TIMEOUT_CYC = FET_TIMEOUT_NS * CLK_MHZ / 1000;
    localparam int unsigned GND_FILT_NS = 1000;
    localparam int unsigned GND_FILT_CYC = (GND_FILT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W = 12;

    typedef enum logic [1:0] {
        FET_IDLE = 2'b01,
        FET_RUN = 2'b10
    } sld_fet_e;
endpackage : sld_pkg

// ===== logic/sld_fet_if.sv
// handshake between the register logic and the fet test sequencer
// assumes both ends run on aclk
interface sld_fet_if;
    logic start;
    logic low_side;
    logic [1:0] chan;
    logic trip;
    logic active;
    logic [3:0] hs_drv;
    logic [3:0] ls_drv;

    modport ctl (output start, output low_side, output chan, output trip,
                 input active, input hs_drv, input ls_drv);
    modport seq (input start, input low_side, input chan, input trip,
                 output active, output hs_drv, output ls_drv);
endinterface : sld_fet_if

// ===== logic/sld_fet_seq.sv
// high-side / low-side fet test sequencer with timeout
// assumes start is a one-cycle pulse, trip is the monitor threshold comparator
module sld_fet_seq (
    input wire logic aclk,
    input wire logic aresetn,
    sld_fet_if.seq fet
);
    sld_pkg::sld_fet_e state_q, state_d;
    logic [sld_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [3:0] hs_q, hs_d, ls_q, ls_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        hs_d = hs_q;
        ls_d = ls_q;
        case (state_q)
            sld_pkg::FET_IDLE: begin
                if (fet.start) begin
                    state_d = sld_pkg::FET_RUN;
                    cnt_d = '0;
                    if (fet.low_side) begin
                        ls_d = 4'h1 << fet.chan;
                    end else begin
                        hs_d = 4'h1 << fet.chan;
                    end
                end
            end
            sld_pkg::FET_RUN: begin
                // driver off on threshold, or at the timeout at the latest
                if (fet.trip || cnt_q == sld_pkg::CNT_W'(sld_pkg::FET_TIMEOUT_CYC - 1)) begin
                    state_d = sld_pkg::FET_IDLE;
                    hs_d = 4'h0;
                    ls_d = 4'h0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: begin
                state_d = sld_pkg::FET_IDLE;
                hs_d = 4'h0;
                ls_d = 4'h0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= sld_pkg::FET_IDLE;
            cnt_q <= '0;
            hs_q <= 4'h0;
            ls_q <= 4'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            hs_q <= hs_d;
            ls_q <= ls_d;
        end
    end

    assign fet.active = (state_q == sld_pkg::FET_RUN);
    assign fet.hs_drv = hs_q;
    assign fet.ls_drv = ls_q;
endmodule : sld_fet_seq

// ===== logic/sld_gnd_filt.sv
// one channel of loss-of-ground-return filtering and latching
// assumes drop is already gated by the test that enables the check
module sld_gnd_filt (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic drop,
    input wire logic clr,
    output logic flag
);
    logic [sld_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic flag_q, flag_d;
    logic hit;

    always_comb begin
        hit = drop && cnt_q == sld_pkg::CNT_W'(sld_pkg::GND_FILT_CYC - 1);
        cnt_d = drop && !hit ? cnt_q + 1'b1 : '0;
        // a new detection wins over the clear-on-read
        flag_d = hit ? 1'b1 : (clr ? 1'b0 : flag_q);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            flag_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule : sld_gnd_filt

// ===== logic/sld_diag.sv
// What this block does
// - shorted open channel pair goes undetected unless pull-downs are disabled
// - step one: source on feed, sink on return
// - bypass step: source on return, sink on
// - auto source switch-off after result read
// - high-res: monitor on feed, sink on return
// - high-resistance flags always live
// - fet tests only in diagnostic state
// - fet command clears short flags first
// - driver off on threshold or timeout
// - fet active flag while driver on
// - fet flags latched until next request
// - ground loss bit filtered, latched, read-cleared
// - safing code enables safing supply regulator
// - safing and supply voltages via conversion
// - leakage short flags live, with channel, pin
// - monitor connection drops selected return pull-down
//
// squib loop low-level diagnostic control, AXI4-Lite register slave
// assumes analog comparators, adc and drivers sit outside, synchronous to aclk
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
module sld_diag (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sld_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [sld_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic diag_state,
    input wire logic cmp_short_battery,
    input wire logic cmp_short_ground,
    input wire logic cmp_high_res_upper,
    input wire logic cmp_high_res_lower,
    input wire logic [3:0] gnd_drop,
    input wire logic adc_done,
    input wire logic [9:0] adc_data,
    output logic [3:0] src_feed_en,
    output logic [3:0] src_return_en,
    output logic [3:0] sink_en,
    output logic [3:0] mon_feed_en,
    output logic [3:0] mon_return_en,
    output logic [3:0] pulldown_en,
    output logic [3:0] hs_drv_en,
    output logic [3:0] ls_drv_en,
    output logic safing_reg_en,
    output logic adc_start,
    output logic [2:0] adc_sel
);
    sld_fet_if fet ();

    // bus handshake state
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [sld_pkg::AXI_AW-1:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    // register file state
    logic [31:0] cfg_q, cfg_d;
    logic [9:0] lreq_q, lreq_d;
    logic stb_l_q, stb_l_d, stg_l_q, stg_l_d, latched_q, latched_d;
    logic [9:0] conv_q, conv_d;
    logic conv_valid_q, conv_valid_d;
    logic adc_start_q, adc_start_d;
    logic [2:0] adc_sel_q, adc_sel_d;
    logic fet_start_q, fet_start_d, fet_ls_q, fet_ls_d, safing_q, safing_d;

    logic do_wr, rd_fire, gnd_clr, mapped_wr, mapped_rd;
    logic [31:0] old_val, wr_val, rd_val, stat_val;
    logic [3:0] gnd_flag, gnd_in, ch_hot;
    logic [1:0] ch;
    sld_pkg::sld_mode_e mode;

    assign ch = lreq_q[sld_pkg::LRQ_CH_LSB +: 2];
    assign mode = sld_pkg::sld_mode_e'(lreq_q[sld_pkg::LRQ_MODE_LSB +: 2]);
    assign ch_hot = 4'h1 << ch;

    assign fet.start = fet_start_q;
    assign fet.low_side = fet_ls_q;
    assign fet.chan = ch;
    // high-side test ends on the battery-side current, low-side on the ground-side
    assign fet.trip = fet_ls_q ? cmp_short_ground : cmp_short_battery;

    sld_fet_seq u_fet (
        .aclk(aclk),
        .aresetn(aresetn),
        .fet(fet)
    );

    // loss of ground return is checked only while resistance or high-side tests run
    for (genvar i = 0; i < 4; i++) begin : g_gnd
        assign gnd_in[i] = gnd_drop[i] && ch_hot[i] &&
            (((mode == sld_pkg::MODE_RES_STEP1 || mode == sld_pkg::MODE_RES_BYPASS) &&
              lreq_q[sld_pkg::LRQ_SRC]) || (fet.active && !fet_ls_q));
        sld_gnd_filt u_filt (
            .aclk(aclk),
            .aresetn(aresetn),
            .drop(gnd_in[i]),
            .clr(gnd_clr),
            .flag(gnd_flag[i])
        );
    end

    // live comparators unless a fet test has latched them
    always_comb begin
        stat_val = 32'h0000_0000;
        stat_val[sld_pkg::ST_STB] = latched_q ? stb_l_q : cmp_short_battery;
        stat_val[sld_pkg::ST_STG] = latched_q ? stg_l_q : cmp_short_ground;
        stat_val[sld_pkg::ST_HR_UP] = cmp_high_res_upper;
        stat_val[sld_pkg::ST_HR_LO] = cmp_high_res_lower;
        stat_val[sld_pkg::ST_FET_ON] = fet.active;
        stat_val[sld_pkg::ST_CH_LSB +: 2] = ch;
        stat_val[sld_pkg::ST_PIN] = lreq_q[sld_pkg::LRQ_PIN];
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        mapped_rd = 1'b1;
        case (araddr)
            sld_pkg::OFS_SYSTEM_CONFIG: rd_val = cfg_q;
            sld_pkg::OFS_LOOP_REQ: rd_val = {22'h0, lreq_q};
            sld_pkg::OFS_SYS_REQ: rd_val = {31'h0, safing_q};
            sld_pkg::OFS_DIAG_CTL: rd_val = {29'h0, adc_sel_q};
            sld_pkg::OFS_CONV_RES: rd_val = {16'h0, conv_valid_q, 5'h0, conv_q};
            sld_pkg::OFS_LOOP_STAT: rd_val = stat_val;
            sld_pkg::OFS_GND_LOSS: rd_val = {28'h0, gnd_flag};
            default: mapped_rd = 1'b0;
        endcase
    end

    always_comb begin
        old_val = 32'h0000_0000;
        mapped_wr = 1'b1;
        case (aw_addr_q)
            sld_pkg::OFS_SYSTEM_CONFIG: old_val = cfg_q;
            sld_pkg::OFS_LOOP_REQ: old_val = {22'h0, lreq_q};
            sld_pkg::OFS_SYS_REQ: old_val = 32'h0000_0000;
            sld_pkg::OFS_DIAG_CTL: old_val = {29'h0, adc_sel_q};
            default: mapped_wr = 1'b0;
        endcase
        for (int b = 0; b < 4; b++) begin
            wr_val[8*b +: 8] = w_strb_q[b] ? w_data_q[8*b +: 8] : old_val[8*b +: 8];
        end
    end

    assign do_wr = aw_have_q && w_have_q;
    assign rd_fire = arvalid && arready_q;
    assign gnd_clr = rd_fire && araddr == sld_pkg::OFS_GND_LOSS;

    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        cfg_d = cfg_q;
        lreq_d = lreq_q;
        stb_l_d = stb_l_q;
        stg_l_d = stg_l_q;
        latched_d = latched_q;
        conv_d = conv_q;
        conv_valid_d = conv_valid_q;
        adc_start_d = 1'b0;
        adc_sel_d = adc_sel_q;
        fet_start_d = 1'b0;
        fet_ls_d = fet_ls_q;
        safing_d = safing_q && diag_state;

        if (awvalid && awready_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = awaddr;
        end
        if (wvalid && wready_q) begin
            w_have_d = 1'b1;
            w_data_d = wdata;
            w_strb_d = wstrb;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        // each write is one explicit host step
        if (do_wr) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = mapped_wr ? sld_pkg::RESP_OKAY : sld_pkg::RESP_SLVERR;
            case (aw_addr_q)
                sld_pkg::OFS_SYSTEM_CONFIG: cfg_d = wr_val;
                sld_pkg::OFS_LOOP_REQ: begin
                    // pull-down disable and routing come from this word
                    lreq_d = wr_val[9:0];
                    latched_d = 1'b0;
                    stb_l_d = 1'b0;
                    stg_l_d = 1'b0;
                end
                sld_pkg::OFS_SYS_REQ: begin
                    latched_d = 1'b0;
                    stb_l_d = 1'b0;
                    stg_l_d = 1'b0;
                    safing_d = 1'b0;
                    // outside the diagnostic state test codes are ignored
                    if (diag_state) begin
                        case (wr_val[1:0])
                            sld_pkg::DST_HS_FET: begin
                                fet_start_d = !fet.active;
                                fet_ls_d = 1'b0;
                            end
                            sld_pkg::DST_LS_FET: begin
                                fet_start_d = !fet.active;
                                fet_ls_d = 1'b1;
                            end
                            sld_pkg::DST_SAFING: safing_d = 1'b1;
                            default: safing_d = 1'b0;
                        endcase
                    end
                end
                sld_pkg::OFS_DIAG_CTL: begin
                    adc_start_d = 1'b1;
                    adc_sel_d = wr_val[2:0];
                    conv_valid_d = 1'b0;
                end
                default: bresp_d = sld_pkg::RESP_SLVERR;
            endcase
        end

        if (fet_start_q) begin
            latched_d = 1'b1;
        end
        // flags caught during the test survive a clear in the same cycle
        if (fet.active && cmp_short_battery) begin
            stb_l_d = 1'b1;
        end
        if (fet.active && cmp_short_ground) begin
            stg_l_d = 1'b1;
        end
        if (adc_done) begin
            conv_d = adc_data;
            conv_valid_d = 1'b1;
        end

        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rdata_d = rd_val;
            rresp_d = mapped_rd ? sld_pkg::RESP_OKAY : sld_pkg::RESP_SLVERR;
            if (araddr == sld_pkg::OFS_CONV_RES) begin
                if (!adc_done) begin
                    conv_valid_d = 1'b0;
                end
                if (cfg_q[sld_pkg::CFG_AUTO_OFF]) begin
                    lreq_d[sld_pkg::LRQ_SRC] = 1'b0;
                    lreq_d[sld_pkg::LRQ_SNK] = 1'b0;
                end
            end
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= sld_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= sld_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            cfg_q <= sld_pkg::CFG_RST;
            lreq_q <= sld_pkg::LRQ_RST;
            stb_l_q <= 1'b0;
            stg_l_q <= 1'b0;
            latched_q <= 1'b0;
            conv_q <= 10'h000;
            conv_valid_q <= 1'b0;
            adc_start_q <= 1'b0;
            adc_sel_q <= 3'h0;
            fet_start_q <= 1'b0;
            fet_ls_q <= 1'b0;
            safing_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q <= w_have_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            cfg_q <= cfg_d;
            lreq_q <= lreq_d;
            stb_l_q <= stb_l_d;
            stg_l_q <= stg_l_d;
            latched_q <= latched_d;
            conv_q <= conv_d;
            conv_valid_q <= conv_valid_d;
            adc_start_q <= adc_start_d;
            adc_sel_q <= adc_sel_d;
            fet_start_q <= fet_start_d;
            fet_ls_q <= fet_ls_d;
            safing_q <= safing_d;
        end
    end

    // analog routing, registered so the pins never glitch
    logic [3:0] srcf_q, srcf_d, srcr_q, srcr_d, snk_q, snk_d;
    logic [3:0] monf_q, monf_d, monr_q, monr_d, pd_q, pd_d;

    always_comb begin
        srcf_d = 4'h0;
        srcr_d = 4'h0;
        snk_d = lreq_q[sld_pkg::LRQ_SNK] ? ch_hot : 4'h0;
        monf_d = 4'h0;
        monr_d = 4'h0;
        if (lreq_q[sld_pkg::LRQ_SRC]) begin
            if (mode == sld_pkg::MODE_RES_BYPASS) begin
                srcr_d = ch_hot;
            end else begin
                srcf_d = ch_hot;
            end
        end
        if (mode == sld_pkg::MODE_HIGH_RES) begin
            monf_d = ch_hot;
            snk_d = ch_hot;
        end else if (lreq_q[sld_pkg::LRQ_MON]) begin
            monf_d = lreq_q[sld_pkg::LRQ_PIN] ? 4'h0 : ch_hot;
            monr_d = lreq_q[sld_pkg::LRQ_PIN] ? ch_hot : 4'h0;
        end
        // unless pull-down disable is set, a shorted open-channel pair is still masked by the remaining pull-downs
        pd_d = lreq_q[sld_pkg::LRQ_PD_OFF] ? 4'h0 : 4'hf;
        if (lreq_q[sld_pkg::LRQ_MON] || mode == sld_pkg::MODE_HIGH_RES) begin
            pd_d = pd_d & ~ch_hot;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            srcf_q <= 4'h0;
            srcr_q <= 4'h0;
            snk_q <= 4'h0;
            monf_q <= 4'h0;
            monr_q <= 4'h0;
            pd_q <= 4'hf;
        end else begin
            srcf_q <= srcf_d;
            srcr_q <= srcr_d;
            snk_q <= snk_d;
            monf_q <= monf_d;
            monr_q <= monr_d;
            pd_q <= pd_d;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bresp = bresp_q;
    assign bvalid = bvalid_q;
    assign arready = arready_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign rvalid = rvalid_q;
    assign src_feed_en = srcf_q;
    assign src_return_en = srcr_q;
    assign sink_en = snk_q;
    assign mon_feed_en = monf_q;
    assign mon_return_en = monr_q;
    assign pulldown_en = pd_q;
    assign hs_drv_en = fet.hs_drv;
    assign ls_drv_en = fet.ls_drv;
    assign safing_reg_en = safing_q;
    assign adc_start = adc_start_q;
    assign adc_sel = adc_sel_q;
endmodule : sld_diag

// ===== sim/sld_diag_checker.sv
// port assertions for sld_diag
// assumes one clock, aclk, with synchronous active-low aresetn
module sld_diag_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic diag_state,
    input wire logic cmp_short_battery,
    input wire logic [3:0] src_feed_en,
    input wire logic [3:0] src_return_en,
    input wire logic [3:0] mon_feed_en,
    input wire logic [3:0] pulldown_en,
    input wire logic [3:0] hs_drv_en,
    input wire logic [3:0] ls_drv_en,
    input wire logic safing_reg_en
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // 500-cycle timeout plus two edges of start latency
    sequence s_off(x); ##[1:502] !x; endsequence
    property p_hs_end; $rose(|hs_drv_en) |-> s_off(|hs_drv_en); endproperty
    a_hs_end: assert property (p_hs_end) else $error("hs on too long");
    property p_ls_end; $rose(|ls_drv_en) |-> s_off(|ls_drv_en); endproperty
    a_ls_end: assert property (p_ls_end) else $error("ls on too long");
    property p_trip; (|hs_drv_en) && cmp_short_battery |-> ##[1:2] !(|hs_drv_en); endproperty
    a_trip: assert property (p_trip) else $error("hs kept on");
    property p_diag; $rose(|(hs_drv_en | ls_drv_en)) |-> $past(diag_state); endproperty
    a_diag: assert property (p_diag) else $error("fet outside diag");
    property p_safe; $rose(safing_reg_en) |-> $past(diag_state); endproperty
    a_safe: assert property (p_safe) else $error("safing outside diag");
    property p_one; $onehot0({hs_drv_en, ls_drv_en}); endproperty
    a_one: assert property (p_one) else $error("two drivers on");
    property p_pd; (mon_feed_en & pulldown_en) == 4'h0; endproperty
    a_pd: assert property (p_pd) else $error("pull-down under monitor");
    property p_src; (src_feed_en & src_return_en) == 4'h0; endproperty
    a_src: assert property (p_src) else $error("source on both pins");
endmodule : sld_diag_checker

// ===== sim/sld_host.sv
// axi4-lite master standing in for the host controller
// assumes the bench watchdog bounds every wait
module sld_host (
    input wire logic aclk,
    output logic [4:0] awaddr = 5'h0,
    output logic awvalid = 1'b0,
    input wire logic awready,
    output logic [31:0] wdata = 32'h0,
    output logic wvalid = 1'b0,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready = 1'b0,
    output logic [4:0] araddr = 5'h0,
    output logic arvalid = 1'b0,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // the leading edge keeps a release and a new request out of one time step
    task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            r = bresp;
        end while (!bvalid);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            d = rdata;
            r = rresp;
        end while (!rvalid);
        rready <= 1'b0;
    endtask : rd
endmodule : sld_host

// ===== sim/test_sld_diag.sv
// bench for sld_diag: register sequences through sld_host
// assumes the bench stands in for comparators, adc and ground sense
module test_sld_diag;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, diag_state = 1'b0, adc_done = 1'b0;
    logic cmp_short_battery = 1'b0, cmp_short_ground = 1'b0;
    logic cmp_high_res_upper = 1'b0, cmp_high_res_lower = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, awvalid, wvalid, bready, arvalid, rready;
    logic safing_reg_en, adc_start;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [1:0] bresp, rresp, rs;
    logic [3:0] gnd_drop = 4'h0, src_feed_en, src_return_en, sink_en, mon_feed_en;
    logic [3:0] mon_return_en, pulldown_en, hs_drv_en, ls_drv_en;
    logic [2:0] adc_sel;
    int fails = 0, n_checks = 0;
    always #2 aclk = ~aclk;
    // the converter answers one cycle after each start
    always @(posedge aclk) adc_done <= adc_start;
    sld_diag dut (.wstrb(4'hf), .adc_data(10'h2a5), .*);
    sld_host host (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
        host.rd(a, rv, rs);
        chk(rv, e);
        chk({30'h0, rs}, {30'h0, er});
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        host.wr(a, d, rs);
        chk({30'h0, rs}, {30'h0, sld_pkg::RESP_OKAY});
    endtask : wr
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    initial begin
        #100000;
        fails++;
        print_verdict();
    end
    initial begin
        cyc(16);
        aresetn <= 1'b1;
        rd(sld_pkg::OFS_LOOP_REQ, 32'h0, sld_pkg::RESP_OKAY);
        rd(5'h1c, 32'h0, sld_pkg::RESP_SLVERR);
        wr(sld_pkg::OFS_LOOP_REQ, 32'h11a);
        cyc(1);
        chk({20'h0, src_feed_en, src_return_en, sink_en}, 32'h404);
        wr(sld_pkg::OFS_SYSTEM_CONFIG, 32'h1);
        wr(sld_pkg::OFS_DIAG_CTL, 32'h3);
        cyc(4);
        chk({29'h0, adc_sel}, 32'h3);
        rd(sld_pkg::OFS_CONV_RES, 32'h82a5, sld_pkg::RESP_OKAY);
        cyc(2);
        chk({24'h0, src_feed_en, sink_en}, 32'h0);
        wr(sld_pkg::OFS_LOOP_REQ, 32'h331);
        {cmp_high_res_upper, cmp_short_ground} <= 2'h3;
        cyc(2);
        chk({20'h0, mon_feed_en, sink_en, pulldown_en}, 32'h22d);
        rd(sld_pkg::OFS_LOOP_STAT, 32'h106, sld_pkg::RESP_OKAY);
        {cmp_high_res_upper, cmp_high_res_lower, cmp_short_ground} <= 3'h2;
        cyc(2);
        rd(sld_pkg::OFS_LOOP_STAT, 32'h108, sld_pkg::RESP_OKAY);
        cmp_high_res_lower <= 1'b0;
        wr(sld_pkg::OFS_LOOP_REQ, 32'h108);
        gnd_drop <= 4'h5;
        cyc(260);
        gnd_drop <= 4'h0;
        rd(sld_pkg::OFS_GND_LOSS, 32'h1, sld_pkg::RESP_OKAY);
        rd(sld_pkg::OFS_GND_LOSS, 32'h0, sld_pkg::RESP_OKAY);
        wr(sld_pkg::OFS_SYS_REQ, 32'h1);
        cyc(4);
        chk({24'h0, hs_drv_en, ls_drv_en}, 32'h0);
        diag_state <= 1'b1;
        wr(sld_pkg::OFS_LOOP_REQ, 32'h23);
        wr(sld_pkg::OFS_SYS_REQ, 32'h1);
        cyc(3);
        chk({24'h0, hs_drv_en, ls_drv_en}, 32'h80);
        cmp_short_battery <= 1'b1;
        cyc(3);
        cmp_short_battery <= 1'b0;
        rd(sld_pkg::OFS_LOOP_STAT, 32'h301, sld_pkg::RESP_OKAY);
        wr(sld_pkg::OFS_SYS_REQ, 32'h2);
        rd(sld_pkg::OFS_LOOP_STAT, 32'h310, sld_pkg::RESP_OKAY);
        cyc(460);
        chk({24'h0, hs_drv_en, ls_drv_en}, 32'h8);
        cyc(40);
        chk({24'h0, hs_drv_en, ls_drv_en}, 32'h0);
        wr(sld_pkg::OFS_SYS_REQ, 32'h3);
        cyc(2);
        chk({31'h0, safing_reg_en}, 32'h1);
        wr(sld_pkg::OFS_LOOP_REQ, 32'h60);
        cyc(1);
        chk({24'h0, mon_return_en, pulldown_en}, 32'h0);
        print_verdict();
    end
endmodule : test_sld_diag
bind sld_diag sld_diag_checker chk_i (.*);
